//--- core/rtc_pkg.sv
// Shared constants and types for the real-time clock oscillator, detector and timer logic
package rtc_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_MHZ         = 200;                          // ref_clk rate in MHz
	localparam int MCLK_TIMEOUT_NS = 100000;                       // Missing-clock timeout, ns
	localparam int MCLK_CYCLES     = MCLK_TIMEOUT_NS * CLK_MHZ / 1000;
	localparam int BLANK_US        = 2000;                         // Clock-valid blanking, us
	localparam int BLANK_CYCLES    = BLANK_US * CLK_MHZ;
	localparam int STEP_OSC_CYCLES = 64;                           // Oscillator cycles per step

	// ****************************************
	// Widths and reset values
	// ****************************************
	localparam int            LOAD_W    = 4;                       // Load capacitance code width
	localparam logic [3:0]    LOAD_MIN  = 4'h0;                    // Smallest load setting
	localparam logic [3:0]    LOAD_MAX  = 4'hf;                    // Largest load setting
	localparam int            TIMER_W   = 32;                      // Timer and compare width
	localparam logic [31:0]   TIMER_RST = 32'h0000_0000;           // Timer reset value

	// ****************************************
	// Types
	// ****************************************
	// Oscillator configuration bits
	typedef struct packed {
		logic       osc_enable;
		logic       xtal_mode;
		logic       agc_en;
		logic       bias_double_en;
		logic       auto_step_en;
		logic [3:0] load_cap_code;
	} osc_cfg_t;

	// Clock control bits
	typedef struct packed {
		logic missing_clk_det_en;
		logic timer_run;
		logic alarm_event_en;
		logic alarm_autoreset_bit;
	} clk_cfg_t;

	// Destination selection for one event source
	typedef struct packed {
		logic to_irq;
		logic to_wake;
		logic to_reset;
	} route_t;

	// Load capacitance stepping states
	typedef enum logic [1:0] {
		STEP_OFF  = 2'b00,
		STEP_RAMP = 2'b01,
		STEP_HOLD = 2'b10
	} step_state_t;

endpackage

//--- core/rtc_sync2.sv
// Two-flop synchroniser for asynchronous input pins
`timescale 1ns/1ps
module rtc_sync2 #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	// ****************************************
	// Synchroniser stages
	// ****************************************
	logic [W-1:0] meta;     // First stage, read only by the second

	// Two flops, frozen with the clock enable
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			meta <= '0;
			q    <= '0;
		end else if (clk_en) begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

//--- core/rtc_timer.sv
// 32-bit oscillator-driven timer with set, capture, alarm and auto-reset
`timescale 1ns/1ps
module rtc_timer (
	input  wire logic                 ref_clk,
	input  wire logic                 rst_b,
	input  wire logic                 clk_en,
	input  wire logic                 osc_tick,
	input  wire rtc_pkg::clk_cfg_t    clk_cfg,
	input  wire logic [31:0]          alarm_compare_value,
	input  wire logic                 capture_load,
	input  wire logic [31:0]          capture_wdata,
	input  wire logic                 timer_set_req,
	input  wire logic                 timer_capture_req,
	output logic      [31:0]          timer_value,
	output logic      [31:0]          capture_value,
	output logic                      alarm_flag,
	output logic                      set_busy,
	output logic                      capture_busy
);
	import rtc_pkg::*;

	// ****************************************
	// Next-count logic
	// ****************************************
	logic        ar_pend;       // Auto-reset due on next oscillator cycle
	logic [31:0] next_count;    // Counter value after this tick
	logic        next_alarm;    // Alarm flag value after this tick

	// Counter update priority: set, auto-reset, run
	always_comb begin
		next_count = timer_value;
		if (set_busy) begin
			next_count = capture_value;
		end else if (ar_pend) begin
			next_count = TIMER_RST;
		end else if (clk_cfg.timer_run) begin
			next_count = timer_value + 32'h0000_0001;
		end
		next_alarm = clk_cfg.alarm_event_en && (next_count == alarm_compare_value);
	end

	// ****************************************
	// Counter and alarm
	// ****************************************
	// Counter moves only on oscillator ticks
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			timer_value <= TIMER_RST;
		end else if (clk_en && osc_tick) begin
			timer_value <= next_count;
		end
	end

	// Alarm lasts one oscillator cycle while the timer runs, dropped at once when disabled
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			alarm_flag <= 1'b0;
		end else if (clk_en) begin
			if (!clk_cfg.alarm_event_en) begin
				alarm_flag <= 1'b0;
			end else if (osc_tick) begin
				alarm_flag <= next_alarm;
			end
		end
	end

	// Auto-reset armed when the alarm falls
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ar_pend <= 1'b0;
		end else if (clk_en && osc_tick) begin
			ar_pend <= clk_cfg.alarm_autoreset_bit && alarm_flag && !next_alarm;
		end
	end

	// ****************************************
	// Set and capture requests
	// ****************************************
	// Request bits: a new request wins over the hardware clear
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			set_busy     <= 1'b0;
			capture_busy <= 1'b0;
		end else if (clk_en) begin
			set_busy     <= timer_set_req | (set_busy & ~osc_tick);
			capture_busy <= timer_capture_req | (capture_busy & ~osc_tick);
		end
	end

	// Capture register: software load, else snapshot on tick
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			capture_value <= TIMER_RST;
		end else if (clk_en) begin
			if (capture_load) begin
				capture_value <= capture_wdata;
			end else if (osc_tick && capture_busy && !set_busy) begin
				capture_value <= timer_value;
			end
		end
	end

endmodule

//--- core/rtc_osc_ctrl.sv
// Top of the real-time clock: oscillator control, detectors, timer and event routing
`timescale 1ns/1ps

// Function
// - Sixteen load codes, zero smallest, fifteen largest.
// - Auto stepping starts smallest, ramps to final code.
// - Load-ready flag set once final code applied.
// - Bias doubling follows its control bit.
// - Missing-clock detector runs only when enabled.
// - Failure flag when oscillator stuck past timeout.
// - Missing-clock timeout routable to irq, wake, reset.
// - Amplitude detector readable as clock-valid status.
// - Clock-valid forced invalid during startup blanking.
// - 32-bit counter advances per oscillator cycle when running.
// - Alarm event routable to irq, wake, reset.
// - Auto-reset clears counter cycle after alarm falls.
// - Alarm bit written one enables auto-reset.
// - Alarm when counter equals compare value.
// - Alarm cleared on disable, lasts one cycle when running.
// - Set and capture transfers, bits self-clear.
module rtc_osc_ctrl #(
	parameter int MCLK_CYC  = rtc_pkg::MCLK_CYCLES,
	parameter int BLANK_CYC = rtc_pkg::BLANK_CYCLES,
	parameter int STEP_CYC  = rtc_pkg::STEP_OSC_CYCLES
) (
	input  wire logic                 ref_clk,
	input  wire logic                 rst_b,
	input  wire logic                 clk_en,
	input  wire logic                 osc_clk_pin,
	input  wire logic                 amp_detect_pin,
	input  wire rtc_pkg::osc_cfg_t    osc_cfg,
	input  wire rtc_pkg::clk_cfg_t    clk_cfg,
	input  wire rtc_pkg::route_t      fail_route,
	input  wire rtc_pkg::route_t      alarm_route,
	input  wire logic                 osc_fail_clr,
	input  wire logic [31:0]          alarm_compare_value,
	input  wire logic                 capture_load,
	input  wire logic [31:0]          capture_wdata,
	input  wire logic                 timer_set_req,
	input  wire logic                 timer_capture_req,
	output logic      [3:0]           applied_load_cap,
	output logic                      load_ready_flag,
	output logic                      bias_double_out,
	output logic                      agc_out,
	output logic                      osc_fail_flag,
	output logic                      clock_valid_status,
	output logic      [31:0]          timer_value,
	output logic      [31:0]          capture_value,
	output logic                      alarm_flag,
	output logic                      set_busy,
	output logic                      capture_busy,
	output logic                      irq_req,
	output logic                      wake_req,
	output logic                      reset_req
);
	import rtc_pkg::*;

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (MCLK_CYC < 2) begin : g_bad_mclk
		$error("MCLK_CYC must be at least 2");
	end
	if (BLANK_CYC < 1) begin : g_bad_blank
		$error("BLANK_CYC must be at least 1");
	end
	if (STEP_CYC < 1) begin : g_bad_step
		$error("STEP_CYC must be at least 1");
	end

	// ****************************************
	// Counter widths and limits
	// ****************************************
	localparam int MW = $clog2(MCLK_CYC + 1);     // Missing-clock counter width
	localparam int BW = $clog2(BLANK_CYC + 1);    // Blanking counter width
	localparam int SW = $clog2(STEP_CYC + 1);     // Step divider width
	localparam logic [MW-1:0] MCLK_LAST = MW'(MCLK_CYC - 1);
	localparam logic [MW-1:0] MCLK_FULL = MW'(MCLK_CYC);
	localparam logic [BW-1:0] BLANK_END = BW'(BLANK_CYC);
	localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYC - 1);

	// ****************************************
	// Pin synchronisation and edge detection
	// ****************************************
	logic [1:0] pin_sync;       // {amplitude detect, oscillator level}, synchronised
	logic       osc_lvl;        // Synchronised oscillator level
	logic       osc_lvl_d;      // Oscillator level one cycle earlier
	logic       osc_tick;       // One pulse per oscillator rising edge
	logic       osc_change;     // Oscillator level moved this cycle
	logic       amp_ok;         // Synchronised amplitude detector

	// Both analog-side pins cross into ref_clk here
	rtc_sync2 #(
		.W (2)
	) u_sync (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.d       ({amp_detect_pin, osc_clk_pin}),
		.q       (pin_sync)
	);

	assign osc_lvl = pin_sync[0];
	assign amp_ok  = pin_sync[1];

	// Delayed copy of the synchronised level for edge detection
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			osc_lvl_d <= 1'b0;
		end else if (clk_en) begin
			osc_lvl_d <= osc_lvl;
		end
	end

	assign osc_tick   = osc_lvl & ~osc_lvl_d;
	assign osc_change = osc_lvl ^ osc_lvl_d;

	// ****************************************
	// Load capacitance stepping
	// ****************************************
	step_state_t step_state;    // Stepping state
	logic [SW-1:0] step_cnt;    // Oscillator cycles since last step
	logic [3:0]    final_code;  // Programmed final load code

	assign final_code = osc_cfg.load_cap_code;

	// Ramp from the smallest code up to the final one
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			step_state       <= STEP_OFF;
			applied_load_cap <= LOAD_MIN;
			step_cnt         <= '0;
		end else if (clk_en) begin
			unique case (step_state)
				STEP_OFF: begin
					// Oscillator off: park at start point
					step_cnt         <= '0;
					applied_load_cap <= osc_cfg.auto_step_en ? LOAD_MIN : final_code;
					if (osc_cfg.osc_enable) begin
						step_state <= osc_cfg.auto_step_en ? STEP_RAMP : STEP_HOLD;
					end
				end
				STEP_RAMP: begin
					if (!osc_cfg.osc_enable) begin
						step_state <= STEP_OFF;
					end else if (applied_load_cap >= final_code) begin
						// Reached, or code lowered below applied value
						applied_load_cap <= final_code;
						step_state       <= STEP_HOLD;
					end else if (osc_tick) begin
						// Raise one code per step interval
						if (step_cnt == STEP_LAST) begin
							step_cnt         <= '0;
							applied_load_cap <= applied_load_cap + 4'h1;
						end else begin
							step_cnt <= step_cnt + SW'(1);
						end
					end
				end
				STEP_HOLD: begin
					if (!osc_cfg.osc_enable) begin
						step_state <= STEP_OFF;
					end else if (osc_cfg.auto_step_en && final_code > applied_load_cap) begin
						// Higher code while running ramps again
						step_cnt   <= '0;
						step_state <= STEP_RAMP;
					end else begin
						applied_load_cap <= final_code;
					end
				end
				default: begin
					step_state <= STEP_OFF;
				end
			endcase
		end
	end

	// Ready once the applied code equals the programmed code
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			load_ready_flag <= 1'b0;
		end else if (clk_en) begin
			load_ready_flag <= (step_state == STEP_HOLD) && (applied_load_cap == final_code);
		end
	end

	// ****************************************
	// Bias and gain controls
	// ****************************************
	// Analog controls registered from configuration
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			bias_double_out <= 1'b0;
			agc_out         <= 1'b0;
		end else if (clk_en) begin
			bias_double_out <= osc_cfg.bias_double_en;
			agc_out         <= osc_cfg.agc_en & osc_cfg.xtal_mode;
		end
	end

	// ****************************************
	// Missing-clock detector
	// ****************************************
	logic [MW-1:0] mclk_cnt;    // Cycles with oscillator level unchanged
	logic          fail_hit;    // Timeout reached this cycle

	// Stuck-level timeout fires once, then the counter saturates
	assign fail_hit = clk_cfg.missing_clk_det_en && !osc_change && (mclk_cnt == MCLK_LAST);

	// Count while enabled and the level holds
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			mclk_cnt <= '0;
		end else if (clk_en) begin
			if (!clk_cfg.missing_clk_det_en || osc_change) begin
				mclk_cnt <= '0;
			end else if (mclk_cnt != MCLK_FULL) begin
				mclk_cnt <= mclk_cnt + MW'(1);
			end
		end
	end

	// Failure flag: a new timeout wins over a clear
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			osc_fail_flag <= 1'b0;
		end else if (clk_en) begin
			osc_fail_flag <= fail_hit | (osc_fail_flag & ~osc_fail_clr);
		end
	end

	// ****************************************
	// Crystal valid detector with blanking
	// ****************************************
	logic [BW-1:0] blank_cnt;   // Cycles since oscillator switch-on

	// Blanking restarts each time the oscillator is switched off
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			blank_cnt <= '0;
		end else if (clk_en) begin
			if (!osc_cfg.osc_enable) begin
				blank_cnt <= '0;
			end else if (blank_cnt != BLANK_END) begin
				blank_cnt <= blank_cnt + BW'(1);
			end
		end
	end

	// Status shows the amplitude detector only after blanking
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			clock_valid_status <= 1'b0;
		end else if (clk_en) begin
			clock_valid_status <= osc_cfg.osc_enable && (blank_cnt == BLANK_END) && amp_ok;
		end
	end

	// ****************************************
	// Timer and alarm
	// ****************************************
	rtc_timer u_timer (
		.ref_clk             (ref_clk),
		.rst_b               (rst_b),
		.clk_en              (clk_en),
		.osc_tick            (osc_tick),
		.clk_cfg             (clk_cfg),
		.alarm_compare_value (alarm_compare_value),
		.capture_load        (capture_load),
		.capture_wdata       (capture_wdata),
		.timer_set_req       (timer_set_req),
		.timer_capture_req   (timer_capture_req),
		.timer_value         (timer_value),
		.capture_value       (capture_value),
		.alarm_flag          (alarm_flag),
		.set_busy            (set_busy),
		.capture_busy        (capture_busy)
	);

	// ****************************************
	// Event routing
	// ****************************************
	logic alarm_d;              // Alarm flag one cycle earlier
	logic alarm_rise;           // Alarm event pulse

	// Edge of the alarm flag gives a one-cycle event
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			alarm_d <= 1'b0;
		end else if (clk_en) begin
			alarm_d <= alarm_flag;
		end
	end

	assign alarm_rise = alarm_flag & ~alarm_d;

	// Route each event to the selected destinations
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			irq_req   <= 1'b0;
			wake_req  <= 1'b0;
			reset_req <= 1'b0;
		end else if (clk_en) begin
			irq_req   <= (fail_hit & fail_route.to_irq)   | (alarm_rise & alarm_route.to_irq);
			wake_req  <= (fail_hit & fail_route.to_wake)  | (alarm_rise & alarm_route.to_wake);
			reset_req <= (fail_hit & fail_route.to_reset) | (alarm_rise & alarm_route.to_reset);
		end
	end

endmodule

//--- test/rtc_xtal_model.sv
// Crystal source stand-in: square wave on the oscillator pin plus amplitude detector
`timescale 1ns/1ps
module rtc_xtal_model #(
	parameter int HALF = 4
) (
	input  wire logic ref_clk,
	input  wire logic run,
	output logic      osc_clk_pin,
	output logic      amp_detect_pin
);
	int cnt = 0; // Reference cycles into the half period

	initial begin
		osc_clk_pin = 1'h0;
		amp_detect_pin = 1'h0;
	end

	// ****************************************
	// Waveform
	// ****************************************
	// Edges land off the reference edge; a stopped source holds its level, as a dead crystal does
	always @(posedge ref_clk) begin
		amp_detect_pin <= #1.3 run; // Amplitude present only while oscillating
		if (run) begin
			cnt = (cnt + 1) % HALF;
			if (cnt == 0) begin
				osc_clk_pin <= #1.3 ~osc_clk_pin;
			end
		end
	end
endmodule

//--- test/rtc_osc_checker.sv
// Port-level assertions for the real-time clock top
`timescale 1ns/1ps
module rtc_osc_checker (
	input wire logic              ref_clk,
	input wire logic              rst_b,
	input wire rtc_pkg::osc_cfg_t osc_cfg,
	input wire rtc_pkg::clk_cfg_t clk_cfg,
	input wire rtc_pkg::route_t   fail_route,
	input wire rtc_pkg::route_t   alarm_route,
	input wire logic [31:0]       alarm_compare_value,
	input wire logic [3:0]        applied_load_cap,
	input wire logic              load_ready_flag,
	input wire logic              bias_double_out,
	input wire logic              agc_out,
	input wire logic              osc_fail_flag,
	input wire logic              clock_valid_status,
	input wire logic [31:0]       timer_value,
	input wire logic              alarm_flag,
	input wire logic              set_busy,
	input wire logic              irq_req,
	input wire logic              reset_req
);
	import rtc_pkg::*;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// ****************************************
	// Oscillator control
	// ****************************************
	AST_BIAS: assert property ($changed(osc_cfg.bias_double_en) |-> ##[1:3]
		(bias_double_out == osc_cfg.bias_double_en)) else $error("bias output off");
	AST_AGC_SELF: assert property (!osc_cfg.xtal_mode [*3] |-> !agc_out)
		else $error("gain control on in self-oscillate");
	AST_STEP_START: assert property ($rose(osc_cfg.osc_enable) && osc_cfg.auto_step_en
		|=> applied_load_cap == 4'h0) else $error("stepping not from smallest");
	AST_STEP_INC: assert property (osc_cfg.auto_step_en && $stable(osc_cfg) &&
		$changed(applied_load_cap) |-> applied_load_cap == $past(applied_load_cap) + 4'h1)
		else $error("load step not by one");
	AST_READY: assert property ($rose(load_ready_flag) |->
		applied_load_cap == osc_cfg.load_cap_code) else $error("ready before final code");
	AST_BLANK: assert property ($rose(osc_cfg.osc_enable) |=> !clock_valid_status [*8])
		else $error("clock valid during blanking");

	// ****************************************
	// Missing clock
	// ****************************************
	AST_FAIL_EN: assert property ($rose(osc_fail_flag) |-> $past(clk_cfg.missing_clk_det_en))
		else $error("failure flag with detector off");
	AST_FAIL_ROUTE: assert property ($rose(osc_fail_flag) && fail_route.to_reset |-> reset_req)
		else $error("failure not routed to reset");

	// ****************************************
	// Timer and alarm
	// ****************************************
	AST_HOLD: assert property (!clk_cfg.timer_run && !clk_cfg.alarm_autoreset_bit
		&& !set_busy |=> $stable(timer_value)) else $error("stopped timer moved");
	AST_ALARM_EQ: assert property ($rose(alarm_flag) |-> timer_value == alarm_compare_value)
		else $error("alarm without match");
	AST_ALARM_OFF: assert property (!clk_cfg.alarm_event_en |=> !alarm_flag)
		else $error("alarm flag while disabled");
	AST_ALARM_LEN: assert property (alarm_flag [*8] |=> !alarm_flag)
		else $error("alarm flag too long");
	AST_ALARM_ROUTE: assert property ($rose(alarm_flag) && alarm_route.to_irq |=> irq_req)
		else $error("alarm not routed to interrupt");
	AST_SET_DONE: assert property ($rose(set_busy) |-> ##[1:40] !set_busy)
		else $error("set request never cleared");
endmodule

bind rtc_osc_ctrl rtc_osc_checker i_chk (.ref_clk(ref_clk), .rst_b(rst_b), .osc_cfg(osc_cfg),
	.clk_cfg(clk_cfg), .fail_route(fail_route), .alarm_route(alarm_route),
	.alarm_compare_value(alarm_compare_value), .applied_load_cap(applied_load_cap),
	.load_ready_flag(load_ready_flag), .bias_double_out(bias_double_out), .agc_out(agc_out),
	.osc_fail_flag(osc_fail_flag), .clock_valid_status(clock_valid_status),
	.timer_value(timer_value), .alarm_flag(alarm_flag), .set_busy(set_busy),
	.irq_req(irq_req), .reset_req(reset_req));

//--- test/tb.sv
// Self-checking bench for the real-time clock top
`timescale 1ns/1ps
module tb;
	import rtc_pkg::*;

	localparam int MCLK = 20; // Shortened missing-clock timeout
	logic        ref_clk = 1'h0;
	logic        rst_b = 1'h0;
	logic        osc_run = 1'h0;
	logic        osc_clk_pin, amp_detect_pin;
	osc_cfg_t    osc_cfg = '0;
	clk_cfg_t    clk_cfg = '0;
	route_t      fail_route = '0;
	route_t      alarm_route = '0;
	logic        osc_fail_clr = 1'h0, capture_load = 1'h0;
	logic        timer_set_req = 1'h0, timer_capture_req = 1'h0;
	logic [31:0] alarm_compare_value = '0, capture_wdata = '0;
	logic [3:0]  applied_load_cap, code;
	logic        load_ready_flag, bias_double_out, agc_out, osc_fail_flag, clock_valid_status;
	logic [31:0] timer_value, capture_value, model;
	logic        alarm_flag, set_busy, capture_busy, irq_req, wake_req, reset_req;
	logic [31:0] rng = 32'h0000_20ec; // Xorshift state
	int          n_mismatch = 0, samples_checked = 0, cyc = 0, n_ticks = 0, t0;
	int          alarm_at[$]; // Tick count at each alarm

	always #2.5 ref_clk = ~ref_clk;

	rtc_xtal_model i_xtal (.ref_clk(ref_clk), .run(osc_run), .osc_clk_pin(osc_clk_pin),
		.amp_detect_pin(amp_detect_pin));

	rtc_osc_ctrl #(.MCLK_CYC(MCLK), .BLANK_CYC(50), .STEP_CYC(2)) i_dut (.ref_clk(ref_clk),
		.rst_b(rst_b), .clk_en(1'h1), .osc_clk_pin(osc_clk_pin), .amp_detect_pin(amp_detect_pin),
		.osc_cfg(osc_cfg), .clk_cfg(clk_cfg), .fail_route(fail_route), .alarm_route(alarm_route),
		.osc_fail_clr(osc_fail_clr), .alarm_compare_value(alarm_compare_value),
		.capture_load(capture_load), .capture_wdata(capture_wdata), .timer_set_req(timer_set_req),
		.timer_capture_req(timer_capture_req), .applied_load_cap(applied_load_cap),
		.load_ready_flag(load_ready_flag), .bias_double_out(bias_double_out), .agc_out(agc_out),
		.osc_fail_flag(osc_fail_flag), .clock_valid_status(clock_valid_status),
		.timer_value(timer_value), .capture_value(capture_value), .alarm_flag(alarm_flag),
		.set_busy(set_busy), .capture_busy(capture_busy), .irq_req(irq_req), .wake_req(wake_req),
		.reset_req(reset_req));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("Mismatches %0d of %0d checks", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Flag selected by number, so one bounded wait serves all
	function automatic logic pick(input int w);
		case (w)
			0: return load_ready_flag;
			1: return set_busy;
			2: return capture_busy;
			3: return alarm_flag;
			default: return osc_fail_flag;
		endcase
	endfunction

	task automatic wait_for(input int w, input logic v, input int lim);
		int i;
		for (i = 0; i < lim && pick(w) !== v; i++) @(negedge ref_clk);
		check({31'h0, pick(w)}, {31'h0, v});
	endtask

	// Load the capture word, then pulse set or capture and wait for it to clear
	task automatic xfer(input logic [31:0] val, input logic do_set);
		capture_load = 1'h1;
		capture_wdata = val;
		@(negedge ref_clk);
		capture_load = 1'h0;
		timer_set_req = do_set;
		timer_capture_req = !do_set;
		@(negedge ref_clk);
		timer_set_req = 1'h0;
		timer_capture_req = 1'h0;
		@(negedge ref_clk);
		wait_for(do_set ? 1 : 2, 1'h0, 40);
	endtask

	// ****************************************
	// Monitors and watchdog
	// ****************************************
	always @(posedge osc_clk_pin) n_ticks++;

	// Timer must equal the compare word when the alarm rises
	always @(posedge alarm_flag) begin
		alarm_at.push_back(n_ticks);
		#1 check(timer_value, alarm_compare_value);
		repeat (2) @(negedge ref_clk);
		check({31'h0, wake_req}, {31'h0, alarm_route.to_wake});
	end

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			stop_test();
		end
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (2) @(negedge ref_clk);
		rst_b = 1'h1;
		check(timer_value, 32'h0);
		// Crystal start with automatic stepping to a random final code
		osc_run = 1'h1;
		code = 4'(xs() % 15) + 4'h1;
		osc_cfg.xtal_mode = 1'h1;
		osc_cfg.auto_step_en = 1'h1;
		osc_cfg.load_cap_code = code;
		osc_cfg.osc_enable = 1'h1;
		repeat (40) @(negedge ref_clk);
		check({31'h0, clock_valid_status}, 32'h0);
		wait_for(0, 1'h1, 800);
		check({28'h0, applied_load_cap}, {28'h0, code});
		repeat (30) @(negedge ref_clk);
		check({31'h0, clock_valid_status}, 32'h1);
		// Every code applied directly without stepping
		osc_cfg.auto_step_en = 1'h0;
		for (int c = 0; c < 16; c++) begin
			osc_cfg.load_cap_code = 4'(c);
			repeat (3) @(negedge ref_clk);
			check({28'h0, applied_load_cap}, 32'(c));
		end
		// Bias and gain settings in both oscillator modes
		for (int m = 0; m < 4; m++) begin
			osc_cfg.bias_double_en = m[0];
			osc_cfg.xtal_mode = m[1];
			osc_cfg.agc_en = 1'h1;
			repeat (3) @(negedge ref_clk);
			check({31'h0, bias_double_out}, 32'(m[0]));
			check({31'h0, agc_out}, 32'(m[1]));
		end
		osc_cfg.agc_en = 1'h0;
		// Set, hold while stopped, then capture over a decoy word
		model = xs();
		xfer(model, 1'h1);
		check(timer_value, model);
		repeat (40) @(negedge ref_clk);
		check(timer_value, model);
		xfer(~model, 1'h0);
		check(capture_value, model);
		// Count oscillator cycles with the source gated so none is in flight
		osc_run = 1'h0;
		repeat (10) @(negedge ref_clk);
		clk_cfg.timer_run = 1'h1;
		t0 = n_ticks;
		osc_run = 1'h1;
		repeat (200) @(negedge ref_clk);
		osc_run = 1'h0;
		repeat (10) @(negedge ref_clk);
		check(timer_value, model + 32'(n_ticks - t0));
		// Auto-reset alarm: compare two below the wanted period of seven
		clk_cfg.timer_run = 1'h0;
		osc_run = 1'h1;
		xfer(32'h0, 1'h1);
		alarm_compare_value = 32'h5;
		alarm_route = 3'h7;
		clk_cfg.alarm_autoreset_bit = 1'h1;
		clk_cfg.alarm_event_en = 1'h1;
		clk_cfg.timer_run = 1'h1;
		repeat (200) @(negedge ref_clk);
		check(32'(alarm_at.size() > 1), 32'h1);
		check(32'(alarm_at[1] - alarm_at[0]), 32'h7);
		wait_for(3, 1'h1, 80);
		clk_cfg.alarm_event_en = 1'h0;
		@(negedge ref_clk);
		check({31'h0, alarm_flag}, 32'h0);
		clk_cfg.timer_run = 1'h0;
		clk_cfg.alarm_autoreset_bit = 1'h0;
		// Detector armed only after the settings are final
		fail_route = 3'h5;
		clk_cfg.missing_clk_det_en = 1'h1;
		repeat (100) @(negedge ref_clk);
		check({31'h0, osc_fail_flag}, 32'h0);
		osc_run = 1'h0;
		wait_for(4, 1'h1, MCLK + 20);
		clk_cfg.missing_clk_det_en = 1'h0;
		osc_fail_clr = 1'h1;
		@(negedge ref_clk);
		osc_fail_clr = 1'h0;
		repeat (60) @(negedge ref_clk);
		check({31'h0, osc_fail_flag}, 32'h0);
		stop_test();
	end
endmodule
